/* rtl/ricfg_pkg.sv */
package ricfg_pkg;
   // serial frame layout
   localparam int          INSTR_BITS      = 16;
   localparam int          DATA_BITS       = 8;
   localparam int          ADDR_W          = 13;
   localparam int          RW_POS          = 15;
   localparam int          CNT_W           = 5;
   localparam logic [4:0]  CNT_INSTR_DONE  = 5'h10;
   localparam logic [4:0]  CNT_BYTE_DONE   = 5'h17;
   // register offsets
   localparam logic [12:0] OFS_RX_BG       = 13'h001A;
   localparam logic [12:0] OFS_CRYSTAL_RESONATOR_INPUT_TUNE   = 13'h001B;
   localparam logic [12:0] OFS_SPARE_ONE   = 13'h001C;
   localparam logic [12:0] OFS_SPARE_TWO   = 13'h001D;
   localparam logic [12:0] OFS_SPARE_THREE = 13'h001E;
   localparam logic [12:0] OFS_PRI_DIV_HI  = 13'h001F;
   localparam logic [12:0] OFS_PRI_DIV_LO  = 13'h0020;
   // field positions
   localparam int          RX_RST_POS      = 7;
   localparam int          BG_CODE_HI      = 6;
   localparam int          BG_CODE_LO      = 2;
   localparam int          BG_OVR_POS      = 0;
   localparam int          XT_DIS_POS      = 7;
   localparam int          XT_CODE_HI      = 5;
   localparam int          DIV_LO_HI       = 7;
   localparam int          DIV_LO_LO       = 2;
   localparam int          DIV_EN_POS      = 1;
   localparam int          DIV_W           = 14;
   // reset values
   localparam logic [4:0]  BG_CODE_RST     = 5'h00;
   localparam logic        BG_OVR_RST      = 1'b0;
   localparam logic        XT_DIS_RST      = 1'b1;
   localparam logic [5:0]  XT_CODE_RST     = 6'h00;
   localparam logic [13:0] PRI_DIV_RST     = 14'h1000;
   localparam logic        DIV_EN_RST      = 1'b0;
endpackage

/* rtl/ricfg_regs.sv */
// Notes on behaviour
// R1: receiver reset bit clears itself after being written to one.
// R2: receiver reset bit resets detectors, dividers, switchover, oscillator, doubler.
// R3: band gap code 00000 is minimum, 11111 maximum, resets to 00000.
// R4: band gap code has no effect unless override enable bit zero set.
// R5: override enable zero means automatic band gap, one means code sets it.
// R6: crystal override-disable resets to one (automatic); zero selects tuning field.
// R7: host writes zero into unused bit six of crystal register.
// R8: tuning field is inverted binary, 0.25 pF steps; all zeros is 15.75 pF.
// R9: tuning field has effect only while override-disable bit is zero.
// R10: divider high register holds bits 13 to 6 of the divider.
// R11: next register's upper six bits hold divider low bits; reset 4096.
// R12: programmed divider used only when enable set; else strap pins decide.
// R13: unused addresses and bits read zero; writes to them are ignored.
`timescale 1ns/1ps
module ricfg_regs
   import ricfg_pkg::*;
(
   // clock and reset
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESETN_I,
   // 3-wire serial port
   input  wire logic              SCLK_I,
   input  wire logic              CS_N_I,
   input  wire logic              SDIO_I,
   output logic                   SDIO_O,
   output logic                   SDIO_OE_N_O,
   // reference input section
   output logic                   RX_RESET_O,
   output logic                   BG_MANUAL_O,
   output logic [4:0]             BG_CODE_O,
   output logic                   CRYSTAL_RESONATOR_INPUT_MANUAL_O,
   output logic [5:0]             CRYSTAL_RESONATOR_INPUT_CAP_QPF_O,
   // primary reference divider
   input  wire logic [DIV_W-1:0]  DIVIDER_STRAP_VAL_I,
   output logic                   PRI_DIV_SPI_EN_O,
   output logic [DIV_W-1:0]       PRI_DIV_O
);

   logic [2:0]        sclk_s_q;
   logic [1:0]        csn_s_q;
   logic [1:0]        sdio_s_q;
   logic [DIV_W-1:0]  strap_s1_q;
   logic [DIV_W-1:0]  strap_s2_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [14:0]       shift_q;
   logic              rd_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        rd_sh_q;
   logic              drive_q;
   logic              rx_rst_q;
   logic [4:0]        bg_code_q;
   logic              bg_ovr_q;
   logic              xt_dis_q;
   logic [5:0]        xt_code_q;
   logic [DIV_W-1:0]  div_q;
   logic              div_en_q;

   wire               sclk_rise;
   wire               sclk_fall;
   wire               active;
   wire               instr_done;
   wire               byte_done;
   wire               wr_stb;
   wire [7:0]         wr_byte;
   wire [ADDR_W-1:0]  instr_addr;
   wire [ADDR_W-1:0]  next_addr;
   wire [ADDR_W-1:0]  rd_addr;
   // per-register write strobes
   wire               sel_rx_bg;
   wire               sel_crystal_resonator_input;
   wire               sel_div_hi;
   wire               sel_div_lo;

   // register read decode, unmapped space reads zero
   function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_RX_BG:      read_reg = {1'b0, bg_code_q, 1'b0, bg_ovr_q}; // [R1] [R13]
         OFS_CRYSTAL_RESONATOR_INPUT_TUNE:  read_reg = {xt_dis_q, 1'b0, xt_code_q};       // [R13]
         OFS_PRI_DIV_HI: read_reg = div_q[13:6];                       // [R10]
         OFS_PRI_DIV_LO: read_reg = {div_q[5:0], div_en_q, 1'b0};      // [R11]
         default:        read_reg = 8'h00;                             // [R13]
      endcase
   endfunction

   assign sclk_rise  = sclk_s_q[1] & ~sclk_s_q[2];
   assign sclk_fall  = ~sclk_s_q[1] & sclk_s_q[2];
   assign active     = ~csn_s_q[1];
   assign instr_done = active & sclk_rise
                       & (cnt_q == CNT_INSTR_DONE - 5'h01);
   assign byte_done  = active & sclk_rise & (cnt_q == CNT_BYTE_DONE);
   assign wr_stb     = byte_done & ~rd_q;
   assign wr_byte    = {shift_q[6:0], sdio_s_q[1]};
   assign instr_addr = {shift_q[ADDR_W-2:0], sdio_s_q[1]};
   assign next_addr  = addr_q - 13'h0001;
   assign rd_addr    = instr_done ? instr_addr : next_addr;

   // write strobes, spare and unmapped addresses get none
   assign sel_rx_bg  = wr_stb & (addr_q == OFS_RX_BG);
   assign sel_crystal_resonator_input   = wr_stb & (addr_q == OFS_CRYSTAL_RESONATOR_INPUT_TUNE);
   assign sel_div_hi = wr_stb & (addr_q == OFS_PRI_DIV_HI);
   assign sel_div_lo = wr_stb & (addr_q == OFS_PRI_DIV_LO);

   // pin synchronisers
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sclk_s_q   <= 3'h0;
         csn_s_q    <= 2'h3;
         sdio_s_q   <= 2'h0;
         strap_s1_q <= 14'h0000;
         strap_s2_q <= 14'h0000;
      end else begin
         sclk_s_q   <= {sclk_s_q[1:0], SCLK_I};
         csn_s_q    <= {csn_s_q[0], CS_N_I};
         sdio_s_q   <= {sdio_s_q[0], SDIO_I};
         strap_s1_q <= DIVIDER_STRAP_VAL_I;
         strap_s2_q <= strap_s1_q;
      end
   end

   // bit counter, restarts whenever chip select is released
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_q <= 5'h00;
      end else if (!active) begin
         cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         cnt_q <= byte_done ? CNT_INSTR_DONE : cnt_q + 5'h01;
      end
   end

   // serial frame: 16-bit instruction then bytes, address counting down
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         shift_q <= 15'h0000;
         rd_q    <= 1'b0;
         addr_q  <= 13'h0000;
      end else if (active & sclk_rise) begin
         shift_q <= {shift_q[13:0], sdio_s_q[1]};
         if (instr_done) begin
            rd_q   <= shift_q[RW_POS-1];
            addr_q <= instr_addr;
         end else if (byte_done) begin
            addr_q <= next_addr;
         end
      end
   end

   // read data shifter, driven out on falling edges
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd_sh_q <= 8'h00;
         drive_q <= 1'b0;
      end else if (!active) begin
         drive_q <= 1'b0;
      end else if ((instr_done & shift_q[RW_POS-1]) | (byte_done & rd_q)) begin
         rd_sh_q <= read_reg(rd_addr);
         drive_q <= 1'b1;
      end else if (sclk_fall & drive_q & (cnt_q != CNT_INSTR_DONE)) begin
         rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
   end

   // receiver reset, a single pulse that clears itself
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_rst_q <= 1'b0;
      end else begin
         rx_rst_q <= sel_rx_bg & wr_byte[RX_RST_POS];   // [R1] [R2]
      end
   end

   // band gap control
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bg_code_q <= BG_CODE_RST;                      // [R3]
         bg_ovr_q  <= BG_OVR_RST;                       // [R5]
      end else if (sel_rx_bg) begin
         bg_code_q <= wr_byte[BG_CODE_HI:BG_CODE_LO];   // [R3]
         bg_ovr_q  <= wr_byte[BG_OVR_POS];              // [R5]
      end
   end

   // crystal tuning control, bit six is not stored
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         xt_dis_q  <= XT_DIS_RST;                       // [R6]
         xt_code_q <= XT_CODE_RST;                      // [R8]
      end else if (sel_crystal_resonator_input) begin
         xt_dis_q  <= wr_byte[XT_DIS_POS];              // [R6]
         xt_code_q <= wr_byte[XT_CODE_HI:0];            // [R7]
      end
   end

   // primary divider, each byte lands on its own
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         div_q    <= PRI_DIV_RST;                       // [R11]
         div_en_q <= DIV_EN_RST;                        // [R12]
      end else begin
         if (sel_div_hi) begin
            div_q[13:6] <= wr_byte;                     // [R10]
         end
         if (sel_div_lo) begin
            div_q[5:0] <= wr_byte[DIV_LO_HI:DIV_LO_LO]; // [R11]
            div_en_q   <= wr_byte[DIV_EN_POS];          // [R12]
         end
      end
   end

   // outputs to the serial port, the reference input section and the primary divider
   assign SDIO_O           = drive_q & rd_sh_q[7];
   assign SDIO_OE_N_O      = ~drive_q;
   assign RX_RESET_O       = rx_rst_q;                              // [R2]
   assign BG_MANUAL_O      = bg_ovr_q;                              // [R5]
   assign BG_CODE_O        = bg_ovr_q ? bg_code_q : 5'h00;          // [R3] [R4]
   assign CRYSTAL_RESONATOR_INPUT_MANUAL_O    = ~xt_dis_q;                             // [R6]
   assign CRYSTAL_RESONATOR_INPUT_CAP_QPF_O   = xt_dis_q ? 6'h00 : ~xt_code_q;         // [R8] [R9]
   assign PRI_DIV_SPI_EN_O = div_en_q;
   assign PRI_DIV_O        = div_en_q ? div_q : strap_s2_q;         // [R12]

endmodule // ricfg_regs

/* verif/ricfg_properties.sv */
`timescale 1ns/1ps
module ricfg_properties
   import ricfg_pkg::*;
(
   // watched ports
   input  wire logic             SYS_CLK_I,
   input  wire logic             RESETN_I,
   input  wire logic             CS_N_I,
   input  wire logic             SDIO_OE_N_O,
   input  wire logic             RX_RESET_O,
   input  wire logic             BG_MANUAL_O,
   input  wire logic [4:0]       BG_CODE_O,
   input  wire logic             CRYSTAL_RESONATOR_INPUT_MANUAL_O,
   input  wire logic [5:0]       CRYSTAL_RESONATOR_INPUT_CAP_QPF_O,
   input  wire logic [DIV_W-1:0] DIVIDER_STRAP_VAL_I,
   input  wire logic             PRI_DIV_SPI_EN_O,
   input  wire logic [DIV_W-1:0] PRI_DIV_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);
   property p_rx_one; RX_RESET_O |=> !RX_RESET_O; endproperty
   a_rx_one: assert property (p_rx_one) else $error("rx pulse long");
   property p_rx_cs; RX_RESET_O |-> !$past(CS_N_I, 2); endproperty
   a_rx_cs: assert property (p_rx_cs) else $error("rx pulse idle");
   property p_bg_auto; !BG_MANUAL_O |-> BG_CODE_O == 5'h00; endproperty
   a_bg_auto: assert property (p_bg_auto) else $error("bg code");
   property p_bg_hold;
      CS_N_I [*6] |-> $stable(BG_CODE_O) && $stable(BG_MANUAL_O);
   endproperty
   a_bg_hold: assert property (p_bg_hold) else $error("bg moved");
   property p_xt_auto; !CRYSTAL_RESONATOR_INPUT_MANUAL_O |-> CRYSTAL_RESONATOR_INPUT_CAP_QPF_O == 6'h00; endproperty
   a_xt_auto: assert property (p_xt_auto) else $error("crystal_resonator_input cap");
   property p_xt_hold;
      CS_N_I [*6] |-> $stable(CRYSTAL_RESONATOR_INPUT_MANUAL_O) && $stable(CRYSTAL_RESONATOR_INPUT_CAP_QPF_O);
   endproperty
   a_xt_hold: assert property (p_xt_hold) else $error("crystal_resonator_input moved");
   property p_strap;
      !PRI_DIV_SPI_EN_O && $past(RESETN_I, 3)
         |-> PRI_DIV_O == $past(DIVIDER_STRAP_VAL_I, 2);
   endproperty
   a_strap: assert property (p_strap) else $error("strap path");
   property p_div_hold;
      CS_N_I [*6] |-> $stable(PRI_DIV_O) || !PRI_DIV_SPI_EN_O;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("div moved");
   c_rx: cover property (RX_RESET_O);
   c_read: cover property ($fell(SDIO_OE_N_O));
   c_div: cover property ($rose(PRI_DIV_SPI_EN_O));
endmodule // ricfg_properties
bind ricfg_regs ricfg_properties ricfg_properties_i (.*);

/* verif/ricfg_host.sv */
`timescale 1ns/1ps
module ricfg_host
   import ricfg_pkg::*;
(
   // serial pins
   input  wire logic clk_i,
   input  wire logic sdio_i,
   output logic      sclk_o = 1'b0,
   output logic      cs_n_o = 1'b1,
   output logic      sdio_o = 1'b0
);
   // one frame, msb first, 5 cycles per sclk phase
   task automatic xfer(input logic rd, input logic [12:0] a,
                       input logic [7:0] wd, output logic [7:0] q);
      logic [23:0] f;
      f = {rd, 2'b00, a, wd};
      q = 8'h00;
      if (a == OFS_CRYSTAL_RESONATOR_INPUT_TUNE) f[6] = 1'b0;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_o = (rd && i < 8) ? ~sdio_o : f[i];
         repeat (5) @(negedge clk_i);
         if (i < 8) q[i] = sdio_i;
         sclk_o = 1'b1;
         repeat (5) @(negedge clk_i);
         sclk_o = 1'b0;
      end
      repeat (5) @(negedge clk_i);
      cs_n_o = 1'b1;
      sdio_o = ~sdio_o;
      repeat (5) @(negedge clk_i);
   endtask
endmodule // ricfg_host

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench
   import ricfg_pkg::*;
;
   typedef struct packed {logic [12:0] a; logic [7:0] w; logic [7:0] r;}
      ricfg_row_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sclk, cs_n, hd, so, oe_n, rx, bgm, xm, en;
   logic [4:0]  bgc;
   logic [5:0]  cap;
   logic [13:0] strap = 14'h0123;
   logic [13:0] div;
   logic [7:0]  q;
   int          failures = 0;
   int          cmp_count = 0;
   int          rx_cnt = 0;
   wire         sdio = oe_n ? hd : so;
   ricfg_row_t  rows [7] = '{'{OFS_RX_BG, 8'hFD, 8'h7D},
      '{OFS_CRYSTAL_RESONATOR_INPUT_TUNE, 8'h7F, 8'h3F}, '{OFS_SPARE_ONE, 8'hFF, 8'h00},
      '{OFS_SPARE_TWO, 8'hFF, 8'h00}, '{OFS_SPARE_THREE, 8'hFF, 8'h00},
      '{OFS_PRI_DIV_HI, 8'hA5, 8'hA5}, '{OFS_PRI_DIV_LO, 8'hFF, 8'hFE}};
   ricfg_row_t  rv [4] = '{'{OFS_RX_BG, 8'h00, 8'h00},
      '{OFS_CRYSTAL_RESONATOR_INPUT_TUNE, 8'h00, 8'h80}, '{OFS_PRI_DIV_HI, 8'h00, 8'h40},
      '{OFS_PRI_DIV_LO, 8'h00, 8'h00}};
   always #50 clk = ~clk;
   always @(posedge clk) if (rx) rx_cnt <= rx_cnt + 1;
   ricfg_regs ricfg_regs_i (.SYS_CLK_I(clk), .RESETN_I(rst_n),
      .SCLK_I(sclk), .CS_N_I(cs_n), .SDIO_I(sdio), .SDIO_O(so),
      .SDIO_OE_N_O(oe_n), .RX_RESET_O(rx), .BG_MANUAL_O(bgm),
      .BG_CODE_O(bgc), .CRYSTAL_RESONATOR_INPUT_MANUAL_O(xm), .CRYSTAL_RESONATOR_INPUT_CAP_QPF_O(cap),
      .DIVIDER_STRAP_VAL_I(strap), .PRI_DIV_SPI_EN_O(en), .PRI_DIV_O(div));
   ricfg_host ricfg_host_i (.clk_i(clk), .sdio_i(sdio), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdio_o(hd));
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      foreach (rows[k]) begin
         ricfg_host_i.xfer(1'b0, rows[k].a, rows[k].w, q);
         ricfg_host_i.xfer(1'b1, rows[k].a, 8'h00, q);
         chk("readback", {8'h00, rows[k].r}, {8'h00, q});
      end
      chk("rx pulses", 16'h0001, rx_cnt[15:0]);
      chk("band gap", 16'h003F, {10'h000, bgm, bgc});
      chk("crystal_resonator_input", 16'h0040, {9'h000, xm, cap});
      chk("divider", 16'h697F, {1'b0, en, div});
      ricfg_host_i.xfer(1'b0, OFS_CRYSTAL_RESONATOR_INPUT_TUNE, 8'h00, q);
      chk("crystal_resonator_input max", 16'h007F, {9'h000, xm, cap});
      rst_n = 1'b0;
      strap = 14'h1ABC;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("strap div", 16'h1ABC, {1'b0, en, div});
      chk("auto", 16'h0000, {3'h0, bgm, bgc, xm, cap});
      foreach (rv[k]) begin
         ricfg_host_i.xfer(1'b1, rv[k].a, 8'h00, q);
         chk("reset value", {8'h00, rv[k].r}, {8'h00, q});
      end
      results();
   end
endmodule // testbench
